// >>> common/dio_out_if.sv
`timescale 1ns/1ps
interface dio_out_if;
  import dio_pkg::*;
  logic [DIO_OUT_MODE_W-1:0] mode;
  logic [DIO_PARAM_W-1:0] param;
  logic user_level;
  logic overload;
  logic fw_off;
  logic level;
  modport ctrl (output mode, output param, output user_level, output overload, output fw_off,
    input level);
  modport chan (input mode, input param, input user_level, input overload, input fw_off,
    output level);
endinterface

// >>> common/dio_pkg.sv
package dio_pkg;
  localparam int DIO_NUM_IN = 4;
  localparam int DIO_NUM_OUT = 2;
  localparam int DIO_POS_W = 32;
  localparam int DIO_PARAM_W = 32;
  localparam int DIO_IN_MODE_W = 5;
  localparam int DIO_OUT_MODE_W = 5;

  localparam logic [DIO_IN_MODE_W-1:0] DIO_IN_MODE_SWITCH = 5'h16;
  localparam logic [DIO_IN_MODE_W-1:0] DIO_IN_MODE_ANALOG_SIGN = 5'h17;

  localparam logic [1:0] DIO_SRC_SERVICE = 2'h0;
  localparam logic [1:0] DIO_SRC_ANALOG = 2'h3;
  localparam logic [1:0] DIO_OPMODE_POSITION = 2'h2;

  localparam int DIO_RISE_LSB = 0;
  localparam int DIO_FALL_LSB = 8;
  localparam int DIO_CODE_W = 8;

  typedef enum logic [1:0] {
    DIO_FACTOR_ZERO,
    DIO_FACTOR_PLUS,
    DIO_FACTOR_MINUS
  } dio_factor_t;

  localparam logic [DIO_CODE_W-1:0] DIO_CODE_ZERO = 8'h00;
  localparam logic [DIO_CODE_W-1:0] DIO_CODE_PLUS = 8'h01;
  localparam logic [DIO_CODE_W-1:0] DIO_CODE_MINUS = 8'h02;
  localparam logic [DIO_CODE_W-1:0] DIO_CODE_EN_ZERO = 8'h03;
  localparam logic [DIO_CODE_W-1:0] DIO_CODE_EN_PLUS = 8'h04;
  localparam logic [DIO_CODE_W-1:0] DIO_CODE_EN_MINUS = 8'h05;
  localparam logic [DIO_CODE_W-1:0] DIO_CODE_DIS_ZERO = 8'h06;
  localparam logic [DIO_CODE_W-1:0] DIO_CODE_DIS_PLUS = 8'h07;
  localparam logic [DIO_CODE_W-1:0] DIO_CODE_DIS_MINUS = 8'h08;

  localparam logic [DIO_OUT_MODE_W-1:0] DIO_OM_USER = 5'h00;
  localparam logic [DIO_OUT_MODE_W-1:0] DIO_OM_MAINS = 5'h01;
  localparam logic [DIO_OUT_MODE_W-1:0] DIO_OM_SWLIMIT = 5'h02;
  localparam logic [DIO_OUT_MODE_W-1:0] DIO_OM_MOVE_DONE = 5'h03;
  localparam logic [DIO_OUT_MODE_W-1:0] DIO_OM_POS_ERR = 5'h04;
  localparam logic [DIO_OUT_MODE_W-1:0] DIO_OM_POS_GT = 5'h05;
  localparam logic [DIO_OUT_MODE_W-1:0] DIO_OM_POS_LT = 5'h06;
  localparam logic [DIO_OUT_MODE_W-1:0] DIO_OM_WARNING = 5'h07;
  localparam logic [DIO_OUT_MODE_W-1:0] DIO_OM_ENABLE = 5'h08;
  localparam logic [DIO_OUT_MODE_W-1:0] DIO_OM_BRAKE = 5'h0A;
  localparam logic [DIO_OUT_MODE_W-1:0] DIO_OM_FAULT = 5'h0B;
  localparam logic [DIO_OUT_MODE_W-1:0] DIO_OM_VEL_GT = 5'h0C;
  localparam logic [DIO_OUT_MODE_W-1:0] DIO_OM_VEL_LT = 5'h0D;
  localparam logic [DIO_OUT_MODE_W-1:0] DIO_OM_HOMED = 5'h0E;
  localparam logic [DIO_OUT_MODE_W-1:0] DIO_OM_PLS = 5'h0F;
endpackage

// >>> design/dio_function_logic.sv
`timescale 1ns/1ps
module dio_function_logic
  import dio_pkg::*;
#(
  parameter int NUM_IN = DIO_NUM_IN,
  parameter int NUM_OUT = DIO_NUM_OUT,
  parameter int POS_W = DIO_POS_W
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [NUM_IN-1:0] i_din,
  input wire logic [NUM_IN*DIO_IN_MODE_W-1:0] i_input_mode,
  input wire logic [NUM_IN*DIO_PARAM_W-1:0] i_input_function_param,
  input wire logic [1:0] i_base_command_source,
  input wire logic [1:0] i_base_operating_mode,
  input wire logic [NUM_OUT*DIO_OUT_MODE_W-1:0] i_output_mode,
  input wire logic [NUM_OUT*DIO_PARAM_W-1:0] i_output_function_param,
  input wire logic [NUM_OUT-1:0] i_user_level,
  input wire logic [NUM_OUT-1:0] i_overload,
  input wire logic [NUM_OUT-1:0] i_fw_off,
  input wire logic [POS_W-1:0] i_bus_voltage,
  input wire logic [POS_W-1:0] i_undervoltage_level,
  input wire logic [POS_W-1:0] i_overvoltage_level,
  input wire logic i_neg_limit_reached,
  input wire logic i_pos_limit_reached,
  input wire logic i_moving_neg,
  input wire logic i_moving_pos,
  input wire logic i_task_finished,
  input wire logic i_trajectory_zero,
  input wire logic i_next_task_pending,
  input wire logic signed [POS_W-1:0] i_position,
  input wire logic signed [POS_W-1:0] i_target_position,
  input wire logic [POS_W-1:0] i_target_position_window,
  input wire logic signed [POS_W-1:0] i_position_following_error,
  input wire logic i_drive_enabled,
  input wire logic i_warning,
  input wire logic i_brake_released,
  input wire logic i_fault,
  input wire logic signed [POS_W-1:0] i_velocity,
  input wire logic i_homed,
  input wire logic [DIO_PARAM_W-1:0] i_position_switch_flags,
  output logic [1:0] o_command_source_select,
  output logic [1:0] o_operating_mode_select,
  output dio_factor_t o_analog_factor,
  output logic o_software_enable_cmd,
  output logic o_software_disable_cmd,
  output logic [NUM_OUT-1:0] o_dout
);
  function automatic dio_factor_t code_factor(input logic [DIO_CODE_W-1:0] code);
    unique case (code)
      DIO_CODE_PLUS, DIO_CODE_EN_PLUS, DIO_CODE_DIS_PLUS: code_factor = DIO_FACTOR_PLUS;
      DIO_CODE_MINUS, DIO_CODE_EN_MINUS, DIO_CODE_DIS_MINUS: code_factor = DIO_FACTOR_MINUS;
      default: code_factor = DIO_FACTOR_ZERO;
    endcase
  endfunction

  function automatic logic code_valid(input logic [DIO_CODE_W-1:0] code);
    code_valid = code <= DIO_CODE_DIS_MINUS;
  endfunction

  function automatic logic [POS_W-1:0] abs_val(input logic signed [POS_W-1:0] v);
    abs_val = v[POS_W-1] ? POS_W'(-v) : POS_W'(v);
  endfunction

  logic [NUM_IN-1:0] din_prev;
  logic [NUM_IN-1:0] sw_active;
  logic [NUM_IN-1:0] sign_mode;
  logic [NUM_IN-1:0] rise;
  logic [NUM_IN-1:0] fall;
  logic [NUM_IN*DIO_CODE_W-1:0] edge_code;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      din_prev <= '0;
    end else begin
      din_prev <= i_din;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      wire [DIO_IN_MODE_W-1:0] md = i_input_mode[gi*DIO_IN_MODE_W +: DIO_IN_MODE_W];
      wire [DIO_PARAM_W-1:0] pr = i_input_function_param[gi*DIO_PARAM_W +: DIO_PARAM_W];
      assign sw_active[gi] = (md == DIO_IN_MODE_SWITCH) && i_din[gi];
      assign sign_mode[gi] = md == DIO_IN_MODE_ANALOG_SIGN;
      assign rise[gi] = sign_mode[gi] && i_din[gi] && !din_prev[gi];
      assign fall[gi] = sign_mode[gi] && !i_din[gi] && din_prev[gi];
      assign edge_code[gi*DIO_CODE_W +: DIO_CODE_W] = rise[gi] ?
        pr[DIO_RISE_LSB +: DIO_CODE_W] : pr[DIO_FALL_LSB +: DIO_CODE_W];
    end
  endgenerate

  logic [DIO_PARAM_W-1:0] sw_param;
  logic sw_any;
  logic [DIO_CODE_W-1:0] sel_code;
  logic sel_edge;
  always_comb begin
    sw_param = '0;
    sw_any = 1'b0;
    sel_code = '0;
    sel_edge = 1'b0;
    for (int k = NUM_IN - 1; k >= 0; k--) begin
      if (sw_active[k]) begin
        sw_any = 1'b1;
        sw_param = i_input_function_param[k*DIO_PARAM_W +: DIO_PARAM_W];
      end
      if (rise[k] || fall[k]) begin
        sel_edge = 1'b1;
        sel_code = edge_code[k*DIO_CODE_W +: DIO_CODE_W];
      end
    end
  end

  // Switch parameter holds source in tens digit and opmode in units digit.
  wire [DIO_PARAM_W-1:0] sw_tens = sw_param / 10;
  wire [DIO_PARAM_W-1:0] sw_units = sw_param % 10;
  wire [1:0] next_command_source_select = sw_any ? sw_tens[1:0]
    : i_base_command_source;
  wire [1:0] next_operating_mode_select = sw_any ? sw_units[1:0]
    : i_base_operating_mode;

  wire analog_src = o_command_source_select == DIO_SRC_ANALOG;
  wire apply_edge = sel_edge && analog_src && code_valid(sel_code);
  wire en_code = sel_code >= DIO_CODE_EN_ZERO && sel_code <= DIO_CODE_EN_MINUS;
  wire dis_code = sel_code >= DIO_CODE_DIS_ZERO && sel_code <= DIO_CODE_DIS_MINUS;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_command_source_select <= DIO_SRC_SERVICE;
      o_operating_mode_select <= '0;
    end else begin
      o_command_source_select <= next_command_source_select;
      o_operating_mode_select <= next_operating_mode_select;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_analog_factor <= DIO_FACTOR_PLUS;
      o_software_enable_cmd <= 1'b0;
      o_software_disable_cmd <= 1'b0;
    end else begin
      if (apply_edge) begin
        o_analog_factor <= code_factor(sel_code);
      end
      o_software_enable_cmd <= apply_edge && en_code;
      o_software_disable_cmd <= apply_edge && dis_code;
    end
  end

  wire bus_ok = i_bus_voltage > i_undervoltage_level
    && i_bus_voltage < i_overvoltage_level;
  wire swlim_hit = (i_neg_limit_reached && i_moving_neg)
    || (i_pos_limit_reached && i_moving_pos);
  // One extra bit keeps the position difference from wrapping at the range ends.
  wire signed [POS_W:0] pos_delta = (POS_W+1)'(i_position) - (POS_W+1)'(i_target_position);
  wire [POS_W:0] delta_abs = pos_delta[POS_W] ? (POS_W+1)'(-pos_delta) : pos_delta;
  wire move_done = i_task_finished && i_trajectory_zero && !i_next_task_pending
    && delta_abs <= {1'b0, i_target_position_window};
  wire homing_mode_ok = o_operating_mode_select == DIO_OPMODE_POSITION
    && o_command_source_select == DIO_SRC_SERVICE;
  wire [POS_W-1:0] abs_err = abs_val(i_position_following_error);
  wire [POS_W-1:0] abs_vel = abs_val(i_velocity);

  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      dio_out_if port_if ();
      assign port_if.mode = i_output_mode[gi*DIO_OUT_MODE_W +: DIO_OUT_MODE_W];
      assign port_if.param = i_output_function_param[gi*DIO_PARAM_W +: DIO_PARAM_W];
      assign port_if.user_level = i_user_level[gi];
      assign port_if.overload = i_overload[gi];
      assign port_if.fw_off = i_fw_off[gi];
      assign o_dout[gi] = port_if.level;
      dio_out_chan u_chan (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_bus_ok(bus_ok),
        .i_swlim_hit(swlim_hit),
        .i_move_done(move_done),
        .i_drive_enabled(i_drive_enabled),
        .i_abs_pos_err(abs_err),
        .i_position(i_position),
        .i_warning(i_warning),
        .i_brake_released(i_brake_released),
        .i_fault(i_fault),
        .i_abs_velocity(abs_vel),
        .i_homed(i_homed),
        .i_homing_mode_ok(homing_mode_ok),
        .i_position_switch_flags(i_position_switch_flags),
        .ch(port_if.chan)
      );
    end
  endgenerate
endmodule // dio_function_logic

// >>> design/dio_out_chan.sv
`timescale 1ns/1ps
module dio_out_chan
  import dio_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_bus_ok,
  input wire logic i_swlim_hit,
  input wire logic i_move_done,
  input wire logic i_drive_enabled,
  input wire logic [DIO_POS_W-1:0] i_abs_pos_err,
  input wire logic signed [DIO_POS_W-1:0] i_position,
  input wire logic i_warning,
  input wire logic i_brake_released,
  input wire logic i_fault,
  input wire logic [DIO_POS_W-1:0] i_abs_velocity,
  input wire logic i_homed,
  input wire logic i_homing_mode_ok,
  input wire logic [DIO_PARAM_W-1:0] i_position_switch_flags,
  dio_out_if.chan ch
);
  logic tripped;
  logic func;
  wire signed [DIO_POS_W-1:0] param_s = ch.param;
  always_comb begin
    unique case (ch.mode)
      DIO_OM_USER: func = ch.user_level;
      DIO_OM_MAINS: func = i_bus_ok;
      DIO_OM_SWLIMIT: func = i_swlim_hit;
      DIO_OM_MOVE_DONE: func = i_move_done;
      DIO_OM_POS_ERR: func = i_drive_enabled && (i_abs_pos_err < ch.param);
      DIO_OM_POS_GT: func = i_position > param_s;
      DIO_OM_POS_LT: func = i_position < param_s;
      DIO_OM_WARNING: func = i_warning;
      DIO_OM_ENABLE: func = i_drive_enabled;
      DIO_OM_BRAKE: func = i_brake_released;
      DIO_OM_FAULT: func = i_fault;
      DIO_OM_VEL_GT: func = i_abs_velocity > ch.param;
      DIO_OM_VEL_LT: func = i_abs_velocity < ch.param;
      DIO_OM_HOMED: func = i_homed && i_homing_mode_ok;
      DIO_OM_PLS: func = |(i_position_switch_flags & ch.param);
      default: func = 1'b0;
    endcase
  end
  wire release_trip = ch.fw_off && !ch.overload;
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      tripped <= 1'b0;
    end else if (ch.overload) begin
      tripped <= 1'b1;
    end else if (release_trip) begin
      tripped <= 1'b0;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ch.level <= 1'b0;
    end else begin
      ch.level <= func && !tripped && !ch.overload && !ch.fw_off;
    end
  end
endmodule // dio_out_chan

// >>> sim/dio_field_model.sv
`timescale 1ns/1ps
module dio_field_model
  import dio_pkg::*;
(
  input wire logic [DIO_NUM_IN-1:0] i_switch,
  input wire logic [DIO_NUM_OUT-1:0] i_dout,
  input wire logic [DIO_NUM_OUT*8-1:0] i_load_ma,
  output logic [DIO_NUM_IN-1:0] o_din,
  output logic [DIO_NUM_OUT-1:0] o_overload
);
  // Switch contacts reach the input pins as they stand.
  assign o_din = i_switch;
  // A driven output into a load above 100 mA senses as overloaded.
  always_comb begin
    for (int k = 0; k < DIO_NUM_OUT; k++) begin
      o_overload[k] = i_dout[k] && (i_load_ma[k*8 +: 8] > 8'h64);
    end
  end
endmodule // dio_field_model

// >>> sim/dio_function_logic_chk.sv
`timescale 1ns/1ps
module dio_function_logic_chk
  import dio_pkg::*;
#(
  parameter int NUM_IN = DIO_NUM_IN,
  parameter int NUM_OUT = DIO_NUM_OUT
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [NUM_IN-1:0] i_din,
  input wire logic [NUM_IN*DIO_IN_MODE_W-1:0] i_input_mode,
  input wire logic [NUM_IN*DIO_PARAM_W-1:0] i_input_function_param,
  input wire logic [1:0] i_base_command_source,
  input wire logic [1:0] i_base_operating_mode,
  input wire logic [NUM_OUT*DIO_OUT_MODE_W-1:0] i_output_mode,
  input wire logic [NUM_OUT-1:0] i_user_level,
  input wire logic [NUM_OUT-1:0] i_overload,
  input wire logic [NUM_OUT-1:0] i_fw_off,
  input wire logic [1:0] o_command_source_select,
  input wire logic [1:0] o_operating_mode_select,
  input wire dio_factor_t o_analog_factor,
  input wire logic o_software_enable_cmd,
  input wire logic o_software_disable_cmd,
  input wire logic [NUM_OUT-1:0] o_dout
);
  logic [NUM_IN-1:0] prev_din;
  logic [NUM_OUT-1:0] lat;
  logic sw_any;
  logic ev;
  logic [31:0] sw_par;
  logic [15:0] p;
  logic [7:0] code;
  always_ff @(posedge i_clk_sys) begin
    prev_din <= i_sys_rst ? '0 : i_din;
    lat <= i_sys_rst ? '0 : (i_overload | (lat & ~i_fw_off));
  end
  always_comb begin
    sw_any = 1'b0;
    sw_par = '0;
    ev = 1'b0;
    code = '0;
    p = '0;
    for (int i = NUM_IN - 1; i >= 0; i--) begin
      p = i_input_function_param[i*DIO_PARAM_W +: 16];
      if (i_din[i] && i_input_mode[i*DIO_IN_MODE_W +: 5] == DIO_IN_MODE_SWITCH) begin
        sw_any = 1'b1;
        sw_par = i_input_function_param[i*DIO_PARAM_W +: 32];
      end
      if (i_din[i] != prev_din[i]
          && i_input_mode[i*DIO_IN_MODE_W +: 5] == DIO_IN_MODE_ANALOG_SIGN) begin
        ev = 1'b1;
        code = i_din[i] ? p[7:0] : p[15:8];
      end
    end
  end
  wire logic [3:0] exp_sel = {2'(sw_par / 32'hA), 2'(sw_par % 32'hA)};
  wire logic [1:0] exp_fac = 2'(code % 8'h03);
  wire logic [NUM_OUT-1:0] ok = ~lat & ~i_overload & ~i_fw_off;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  sequence s_ana_ev;
    ev && code <= 8'h08 && o_command_source_select == DIO_SRC_ANALOG;
  endsequence
  chk_switch_low: assert property (sw_any |=>
    {o_command_source_select, o_operating_mode_select} == $past(exp_sel))
    else $error("selection differs from lowest active switch input");
  chk_switch_base: assert property (!sw_any |=>
    o_command_source_select == $past(i_base_command_source)
    && o_operating_mode_select == $past(i_base_operating_mode))
    else $error("base selection not restored");
  chk_factor_code: assert property (s_ana_ev |=>
    o_analog_factor == $past(exp_fac))
    else $error("analog factor differs from edge code");
  chk_enable_pulse: assert property (s_ana_ev |=>
    o_software_enable_cmd == $past(code >= 8'h03 && code <= 8'h05))
    else $error("software enable pulse wrong");
  chk_disable_pulse: assert property (s_ana_ev |=>
    o_software_disable_cmd == $past(code >= 8'h06))
    else $error("software disable pulse wrong");
  chk_analog_gate: assert property (ev && o_command_source_select != DIO_SRC_ANALOG
    |=> $stable(o_analog_factor) && !o_software_enable_cmd && !o_software_disable_cmd)
    else $error("analog factor changed outside analog source");
  chk_overload_off: assert property (i_overload[0] || lat[0] |=> !o_dout[0])
    else $error("output on during overload latch");
  chk_user_level: assert property (i_output_mode[4:0] == DIO_OM_USER && ok[0]
    |=> o_dout[0] == $past(i_user_level[0]))
    else $error("user mode output does not follow level");
endmodule // dio_function_logic_chk
bind dio_function_logic dio_function_logic_chk #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) u_chk (.*);

// >>> sim/drive_io_function_logic_tb_top.sv
`timescale 1ns/1ps
module drive_io_function_logic_tb_top;
  import dio_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [3:0] sw = 4'h0;
  logic [3:0] i_din;
  logic [19:0] i_input_mode = {5'h17, 5'h16, 5'h16, 5'h16};
  logic [127:0] i_input_function_param = {32'h0, 32'hC, 32'h1, 32'h16};
  logic [1:0] i_base_command_source = 2'h0, i_base_operating_mode = 2'h0;
  logic [9:0] i_output_mode = 10'h0;
  logic [63:0] i_output_function_param = 64'h64;
  logic [1:0] i_user_level = 2'h3, i_fw_off = 2'h0, i_overload, o_dout;
  logic [15:0] load = 16'h0;
  logic [31:0] i_bus_voltage = 32'h32, i_undervoltage_level = 32'hA;
  logic [31:0] i_overvoltage_level = 32'h64, i_target_position_window = 32'hA;
  logic [31:0] i_position_switch_flags = 32'h4;
  logic i_neg_limit_reached = 1'b1, i_pos_limit_reached = 1'b0;
  logic i_moving_neg = 1'b1, i_moving_pos = 1'b0, i_next_task_pending = 1'b0;
  logic i_task_finished = 1'b1, i_trajectory_zero = 1'b1, i_homed = 1'b1;
  logic i_drive_enabled = 1'b1, i_warning = 1'b1, i_brake_released = 1'b1, i_fault = 1'b1;
  logic signed [31:0] i_position = 32'h96, i_target_position = 32'h8C;
  logic signed [31:0] i_position_following_error = -32'sh63, i_velocity = -32'sh65;
  logic [1:0] o_command_source_select, o_operating_mode_select;
  dio_factor_t o_analog_factor;
  logic o_software_enable_cmd, o_software_disable_cmd;
  wire [3:0] ana_out = {o_analog_factor, o_software_enable_cmd, o_software_disable_cmd};
  logic [3:0] sw_seq [6] = '{4'h4, 4'h5, 4'h7, 4'h3, 4'h2, 4'h0};
  logic [3:0] sel_seq [6] = '{4'h6, 4'hA, 4'hA, 4'hA, 4'h1, 4'h0};
  logic [15:0] om_exp [2] = '{16'hDDBF, 16'h2140};
  int bad_count = 0, comparisons = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  dio_field_model u_field (.i_switch(sw), .i_dout(o_dout), .i_load_ma(load), .o_din(i_din),
    .o_overload(i_overload));
  dio_function_logic DUT (.*);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  function automatic logic [3:0] exp_ana(input int c);
    return {2'(c % 3), c >= 3 && c <= 5, c >= 6};
  endfunction
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge i_clk_sys);
    bad_count++;
    print_verdict();
  end
  initial begin
    tick(3);
    check({o_analog_factor, o_dout}, {DIO_FACTOR_PLUS, 2'h0});
    i_sys_rst = 1'b0;
    for (int k = 0; k < 6; k++) begin
      sw = sw_seq[k];
      tick(1);
      check({o_command_source_select, o_operating_mode_select}, sel_seq[k]);
    end
    i_base_command_source = 2'h3;
    tick(1);
    for (int c = 0; c < 9; c++) begin
      i_input_function_param[127:96] = {16'h0, 8'(8 - c), 8'(c)};
      sw[3] = 1'b1;
      tick(1);
      check(ana_out, exp_ana(c));
      tick(1);
      check({o_software_enable_cmd, o_software_disable_cmd}, 2'h0);
      sw[3] = 1'b0;
      tick(1);
      check(ana_out, exp_ana(8 - c));
    end
    i_base_command_source = 2'h0;
    tick(1);
    sw[3] = 1'b1;
    tick(1);
    check(ana_out, 4'h0);
    i_base_command_source = 2'h3;
    i_input_function_param[111:96] = 16'h0109;
    tick(1);
    sw[3] = 1'b0;
    tick(1);
    check(o_analog_factor, DIO_FACTOR_PLUS);
    sw[3] = 1'b1;
    tick(1);
    check(ana_out, 4'h4);
    i_base_command_source = 2'h0;
    i_base_operating_mode = 2'h2;
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < 16; m++) begin
        i_output_mode[4:0] = 5'(m);
        tick(1);
        if (m < 8) begin
          check(o_dout, {1'b1, om_exp[s][m]});
        end else begin
          check(o_dout, {1'b1, om_exp[s][m]});
        end
      end
      {i_user_level, i_bus_voltage, i_moving_neg, i_moving_pos} = {2'h2, 32'h64, 2'h1};
      {i_target_position_window, i_position_following_error} = {32'h9, -32'sh64};
      {i_position, i_warning, i_brake_released, i_fault} = {32'h63, 3'h0};
      {i_velocity, i_base_operating_mode, i_position_switch_flags} = {-32'sh63, 2'h1, 32'h9B};
    end
    {i_output_mode[4:0], i_user_level, load[7:0]} = {5'h0, 2'h3, 8'h96};
    tick(4);
    check(o_dout[0], 1'b0);
    {i_fw_off[0], load[7:0]} = {1'b1, 8'h32};
    tick(1);
    i_fw_off[0] = 1'b0;
    tick(2);
    check(o_dout, 2'h3);
    print_verdict();
  end
endmodule // drive_io_function_logic_tb_top
